// *** fcd_pkg.sv ***
// Purpose: shared constants and types of the configuration decoder
// Assumes: 10 MHz ref_clk, configuration bytes presented by the nv storage
// Notes:   register indices are word indices; byte address is four times the index
package fcd_pkg;
   // register indices
   localparam logic [7:0] IDX_CFG0     = 8'h05;
   localparam logic [7:0] IDX_CFG1     = 8'h06;
   localparam logic [7:0] IDX_APP_END  = 8'h07;
   localparam logic [7:0] IDX_BOOT_END = 8'h08;
   localparam logic [7:0] IDX_KEY      = 8'h0a;
   localparam logic [7:0] IDX_STATUS   = 8'h10;
   // reset values
   localparam logic [7:0] RST_CFG0 = 8'hc4;
   localparam logic [7:0] RST_CFG1 = 8'h07;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // field positions
   localparam int MCHK_LSB   = 6;
   localparam int PINF_LSB   = 2;
   localparam int RETAIN_BIT = 0;
   localparam int DLY_LSB    = 0;
   localparam int ST_LOCKED  = 0;
   localparam int ST_BLANKED = 1;
   localparam int ST_EXEC    = 2;
   // security key that opens the part
   localparam logic [7:0] OPEN_KEY = 8'hc5;
   // flash geometry
   localparam int FA_W        = 17;
   localparam int BLOCK_SHIFT = 8;
   // peripheral windows
   localparam logic [15:0] BASE_SYSCFG  = 16'h0f00;
   localparam logic [15:0] MASK_SYSCFG  = 16'hff00;
   localparam logic [15:0] BASE_FLASHCT = 16'h1000;
   localparam logic [15:0] MASK_FLASHCT = 16'hff00;
   localparam logic [15:0] BASE_FUSES   = 16'h1280;
   localparam logic [15:0] MASK_FUSES   = 16'hff80;
   localparam logic [15:0] BASE_SIGROW  = 16'h1100;
   localparam logic [15:0] MASK_SIGROW  = 16'hff00;
   localparam logic [15:0] BASE_USERROW = 16'h1300;
   localparam logic [15:0] MASK_USERROW = 16'hff80;
   // timing
   localparam int CLK_PERIOD_NS     = 100;
   localparam int MS_NS             = 1000000;
   localparam int MS_CYCLES         = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_SLOW_CYCLES = 768;

   typedef enum logic [1:0] {
      MCHK_FULL      = 2'b00,
      MCHK_BOOT      = 2'b01,
      MCHK_BOOT_CODE = 2'b10,
      MCHK_OFF       = 2'b11
   } fcd_mchk_t;

   typedef enum logic [1:0] {
      PIN_GPIO  = 2'b00,
      PIN_DEBUG = 2'b01,
      PIN_RESET = 2'b10,
      PIN_RSVD  = 2'b11
   } fcd_pinf_t;

   typedef enum logic [1:0] {
      REG_BOOT = 2'b00,
      REG_CODE = 2'b01,
      REG_DATA = 2'b10,
      REG_OUT  = 2'b11
   } fcd_region_t;

   typedef enum logic [2:0] {
      PER_NONE    = 3'b000,
      PER_IO      = 3'b001,
      PER_SYSCFG  = 3'b010,
      PER_FLASHCT = 3'b011,
      PER_SIGROW  = 3'b100,
      PER_FUSES   = 3'b101,
      PER_USERROW = 3'b110
   } fcd_periph_t;
endpackage

// *** fcd_blank_if.sv ***
// Purpose: link between the decoder and its pin blanking timer
// Assumes: slow_tick is a one-cycle pulse per slow oscillator period
// Notes:   done stays high until the next system reset
interface fcd_blank_if;
   logic slow_tick;
   logic done;
   modport owner (output slow_tick, input done);
   modport timer (input slow_tick, output done);
endinterface

// *** fcd_blank_timer.sv ***
// Purpose: counts slow oscillator periods after system reset
// Assumes: ticks are synchronous single-cycle pulses
// Notes:   restarts only through reset
module fcd_blank_timer
   import fcd_pkg::*;
#(
   parameter int COUNT = BLANK_SLOW_CYCLES
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   // timer side of the link
   fcd_blank_if.timer bif
);
   localparam int CW = $clog2(COUNT + 1);

   logic [CW-1:0] cnt_ff;
   logic          done_ff;

   // a zero count would never end the blanking
   if (COUNT < 1) begin
      $error("fcd_blank_timer: COUNT must be at least 1");
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end else if (!done_ff && bif.slow_tick) begin
         cnt_ff  <= cnt_ff + 1'b1;
         done_ff <= (cnt_ff == CW'(COUNT - 1));
      end
   end

   assign bif.done = done_ff;

   property p_blank_len;
      @(posedge ref_clk) disable iff (reset)
      $rose(done_ff) |-> $past(cnt_ff) == CW'(COUNT - 1);
   endproperty
   a_blank_len: assert property (p_blank_len)
      else $error("blanking ended at wrong tick count");
endmodule

// *** fcd_fuse_decode.sv ***
// Purpose: decodes configuration bytes into device-wide settings
// Assumes: fuse bytes stable while reset is high; inputs synchronous to ref_clk
// Notes:   registers readable over apb, byte address = 4 x index
module fcd_fuse_decode
   import fcd_pkg::*;
#(
   parameter int FLASH_BLOCKS = 64,
   parameter int MS_CYC       = MS_CYCLES
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset,
   // configuration storage and reset controller
   input  wire logic [7:0]        nv_cfg0,
   input  wire logic [7:0]        nv_cfg1,
   input  wire logic [7:0]        nv_app_end,
   input  wire logic [7:0]        nv_boot_end,
   input  wire logic [7:0]        nv_key,
   input  wire logic              power_on_flag,
   input  wire logic              slow_tick,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [9:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // cpu and flash controller
   output logic                   exec_ready,
   output logic                   check_en,
   output logic      [FA_W-1:0]   check_end,
   output logic      [FA_W-1:0]   boot_end,
   output logic      [FA_W-1:0]   app_end,
   input  wire logic [FA_W-1:0]   flash_addr,
   output fcd_region_t            flash_region,
   input  wire logic              chip_erase_req,
   output logic                   eeprom_erase,
   // address decoder
   input  wire logic [15:0]       cpu_addr,
   output fcd_periph_t            periph_sel,
   // debug port
   input  wire logic              dbg_req,
   input  wire logic              dbg_cs_space,
   output logic                   dbg_grant,
   output logic                   dbg_sysbus_en,
   // shared pin
   output logic                   pin_gpio_en,
   output logic                   pin_gpio_drive_ok,
   output logic                   pin_debug_en,
   output logic                   pin_reset_en
);
   localparam logic [FA_W-1:0] FLASH_END = FA_W'(FLASH_BLOCKS << BLOCK_SHIFT);
   localparam int              SW        = $clog2(MS_CYC);

   // flash end must fit the address width; the ms prescaler needs two states
   if (FLASH_BLOCKS < 1 || FLASH_BLOCKS > 256) begin
      $error("FLASH_BLOCKS out of range");
   end
   if (MS_CYC < 2) begin
      $error("MS_CYC must be at least 2");
   end

   function automatic logic [FA_W-1:0] blk2addr(input logic [7:0] blk);
      blk2addr = FA_W'(blk) << BLOCK_SHIFT;
   endfunction

   function automatic logic in_win(input logic [15:0] a, input logic [15:0] base,
                                   input logic [15:0] mask);
      in_win = (a & mask) == base;
   endfunction

   function automatic logic [6:0] delay_ms(input logic [2:0] sel);
      delay_ms = (sel == 3'h0) ? 7'h00 : 7'(7'h01 << (sel - 3'h1));
   endfunction

   // latched configuration
   logic [7:0] cfg0_ff;
   logic [7:0] cfg1_ff;
   logic [7:0] app_blk_ff;
   logic [7:0] boot_blk_ff;
   logic [7:0] key_ff;
   logic       por_ff;

   fcd_mchk_t  memcheck_source;
   fcd_pinf_t  shared_pin_function;
   logic       eeprom_retain_on_erase;
   logic [2:0] startup_delay_sel;
   logic       locked;

   // sync reset lets the bytes flow in while reset is held and freeze at release
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg0_ff     <= nv_cfg0;
         cfg1_ff     <= nv_cfg1;
         app_blk_ff  <= nv_app_end;
         boot_blk_ff <= nv_boot_end;
         por_ff      <= power_on_flag;
      end
   end

   // key is the only writable byte; a write can lock or reopen at once
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         key_ff <= nv_key;
      end else if (psel && penable && pwrite && paddr[9:2] == IDX_KEY
                   && paddr[1:0] == 2'b00) begin
         // taken in the access phase, the edge where the master sees pready
         key_ff <= pwdata[7:0];
      end
   end

   assign memcheck_source        = fcd_mchk_t'(cfg0_ff[MCHK_LSB +: 2]);
   assign shared_pin_function    = fcd_pinf_t'(cfg0_ff[PINF_LSB +: 2]);
   assign eeprom_retain_on_erase = cfg0_ff[RETAIN_BIT];
   assign startup_delay_sel      = cfg1_ff[DLY_LSB +: 3];
   assign locked                 = (key_ff != OPEN_KEY);

   // flash partition
   logic [FA_W-1:0] boot_end_ff;
   logic [FA_W-1:0] app_end_ff;
   logic [FA_W-1:0] check_end_ff;
   logic            check_en_ff;
   fcd_region_t     region_ff;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         boot_end_ff <= FLASH_END;
         app_end_ff  <= FLASH_END;
      end else begin
         boot_end_ff <= (boot_blk_ff == RST_BYTE) ? FLASH_END : blk2addr(boot_blk_ff);
         if (boot_blk_ff == RST_BYTE) begin
            app_end_ff <= FLASH_END;
         end else if (app_blk_ff == RST_BYTE) begin
            app_end_ff <= FLASH_END;
         end else begin
            app_end_ff <= blk2addr(app_blk_ff);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         region_ff <= REG_BOOT;
      end else if (flash_addr >= FLASH_END) begin
         region_ff <= REG_OUT;
      end else if (flash_addr < boot_end_ff) begin
         region_ff <= REG_BOOT;
      end else if (flash_addr < app_end_ff) begin
         region_ff <= REG_CODE;
      end else begin
         region_ff <= REG_DATA;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         check_en_ff  <= 1'b0;
         check_end_ff <= '0;
      end else begin
         check_en_ff <= (memcheck_source != MCHK_OFF);
         unique case (memcheck_source)
            MCHK_FULL:      check_end_ff <= FLASH_END;
            MCHK_BOOT:      check_end_ff <= boot_end_ff;
            MCHK_BOOT_CODE: check_end_ff <= app_end_ff;
            MCHK_OFF:       check_end_ff <= '0;
         endcase
      end
   end

   // chip erase: lock overrides retention
   logic eeprom_erase_ff;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         eeprom_erase_ff <= 1'b0;
      end else begin
         eeprom_erase_ff <= chip_erase_req && (!eeprom_retain_on_erase || locked);
      end
   end

   // startup delay, power-on only
   logic [SW-1:0] sub_ff;
   logic [6:0]    ms_ff;
   logic          exec_ff;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sub_ff  <= '0;
         ms_ff   <= '0;
         exec_ff <= 1'b0;
      end else if (!exec_ff) begin
         if (!por_ff || ms_ff == delay_ms(startup_delay_sel)) begin
            exec_ff <= 1'b1;
         end else if (sub_ff == SW'(MS_CYC - 1)) begin
            sub_ff <= '0;
            ms_ff  <= ms_ff + 7'h01;
         end else begin
            sub_ff <= sub_ff + 1'b1;
         end
      end
   end

   // shared pin function and blanking
   fcd_blank_if bif ();
   assign bif.slow_tick = slow_tick;

   fcd_blank_timer #(
      .COUNT   (BLANK_SLOW_CYCLES)
   ) u_blank (
      .ref_clk (ref_clk),
      .reset   (reset),
      .bif     (bif)
   );

   logic gpio_ff;
   logic drive_ok_ff;
   logic debug_ff;
   logic rst_pin_ff;
   // reserved code enables no function at all
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         gpio_ff     <= 1'b0;
         drive_ok_ff <= 1'b0;
         debug_ff    <= 1'b0;
         rst_pin_ff  <= 1'b0;
      end else begin
         gpio_ff     <= (shared_pin_function == PIN_GPIO);
         debug_ff    <= (shared_pin_function == PIN_DEBUG);
         rst_pin_ff  <= (shared_pin_function == PIN_RESET);
         drive_ok_ff <= (shared_pin_function == PIN_GPIO) && bif.done;
      end
   end

   // debug port gating
   logic dbg_grant_ff;
   logic dbg_bus_ff;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dbg_grant_ff <= 1'b0;
         dbg_bus_ff   <= 1'b0;
      end else begin
         dbg_bus_ff   <= !locked;
         dbg_grant_ff <= dbg_req && (!locked || dbg_cs_space);
      end
   end

   // peripheral address decode
   fcd_periph_t periph_ff;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         periph_ff <= PER_NONE;
      end else if (in_win(cpu_addr, BASE_SYSCFG, MASK_SYSCFG)) begin
         periph_ff <= PER_SYSCFG;
      end else if (in_win(cpu_addr, BASE_FLASHCT, MASK_FLASHCT)) begin
         periph_ff <= PER_FLASHCT;
      end else if (in_win(cpu_addr, BASE_SIGROW, MASK_SIGROW)) begin
         periph_ff <= PER_SIGROW;
      end else if (in_win(cpu_addr, BASE_FUSES, MASK_FUSES)) begin
         periph_ff <= PER_FUSES;
      end else if (in_win(cpu_addr, BASE_USERROW, MASK_USERROW)) begin
         periph_ff <= PER_USERROW;
      end else if (cpu_addr < BASE_SYSCFG) begin
         periph_ff <= PER_IO;
      end else begin
         periph_ff <= PER_NONE;
      end
   end

   // apb: answer prepared in setup, so access phase never waits
   logic [31:0] prdata_ff;
   logic        pslverr_ff;
   logic [31:0] rd_word;
   logic        hit;
   logic        ro_hit;

   always_comb begin
      rd_word = '0;
      hit     = 1'b1;
      ro_hit  = 1'b1;
      if (paddr[1:0] != 2'b00) begin
         hit = 1'b0;
      end else begin
         unique case (paddr[9:2])
            IDX_CFG0:     rd_word[7:0] = cfg0_ff;
            IDX_CFG1:     rd_word[7:0] = cfg1_ff;
            IDX_APP_END:  rd_word[7:0] = app_blk_ff;
            IDX_BOOT_END: rd_word[7:0] = boot_blk_ff;
            IDX_KEY: begin
               rd_word[7:0] = key_ff;
               ro_hit       = 1'b0;
            end
            IDX_STATUS: begin
               rd_word[ST_LOCKED]  = locked;
               rd_word[ST_BLANKED] = bif.done;
               rd_word[ST_EXEC]    = exec_ff;
            end
            default: hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prdata_ff  <= '0;
         pslverr_ff <= 1'b0;
      end else if (psel && !penable) begin
         prdata_ff  <= pwrite ? 32'h0000_0000 : rd_word;
         pslverr_ff <= !hit || (pwrite && ro_hit);
      end
   end

   assign pready            = 1'b1;
   assign prdata            = prdata_ff;
   assign pslverr           = pslverr_ff & psel & penable;
   assign exec_ready        = exec_ff;
   assign check_en          = check_en_ff;
   assign check_end         = check_end_ff;
   assign boot_end          = boot_end_ff;
   assign app_end           = app_end_ff;
   assign flash_region      = region_ff;
   assign eeprom_erase      = eeprom_erase_ff;
   assign periph_sel        = periph_ff;
   assign dbg_grant         = dbg_grant_ff;
   assign dbg_sysbus_en     = dbg_bus_ff;
   assign pin_gpio_en       = gpio_ff;
   assign pin_gpio_drive_ok = drive_ok_ff;
   assign pin_debug_en      = debug_ff;
   assign pin_reset_en      = rst_pin_ff;

   // checking helpers
   logic [23:0] elapsed_ff;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         elapsed_ff <= '0;
      end else if (!exec_ff) begin
         elapsed_ff <= elapsed_ff + 24'h000001;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_mchk;
      memcheck_source == MCHK_BOOT ##1 memcheck_source == MCHK_BOOT
         |=> check_en_ff && check_end_ff == $past(boot_end_ff);
   endproperty
   a_mchk: assert property (p_mchk) else $error("memcheck span wrong");

   property p_pin;
      pin_debug_en |-> $past(shared_pin_function) == PIN_DEBUG && !pin_gpio_en && !pin_reset_en;
   endproperty
   a_pin: assert property (p_pin) else $error("pin function wrong");

   property p_blank;
      pin_gpio_drive_ok |-> $past(bif.done) && pin_gpio_en;
   endproperty
   a_blank: assert property (p_blank) else $error("gpio driven during blanking");

   property p_retain;
      chip_erase_req && !locked && eeprom_retain_on_erase |=> !eeprom_erase;
   endproperty
   a_retain: assert property (p_retain) else $error("retained eeprom erased");

   property p_lock_erase;
      chip_erase_req && locked |=> eeprom_erase;
   endproperty
   a_lock_erase: assert property (p_lock_erase) else $error("locked erase kept eeprom");

   property p_delay;
      $rose(exec_ff) && por_ff |-> elapsed_ff >= 24'(int'(delay_ms(startup_delay_sel)) * MS_CYC);
   endproperty
   a_delay: assert property (p_delay) else $error("execution started early");

   property p_app;
      boot_blk_ff != RST_BYTE && app_blk_ff != RST_BYTE
         |=> app_end == blk2addr($past(app_blk_ff));
   endproperty
   a_app: assert property (p_app) else $error("code end wrong");

   property p_boot0;
      boot_blk_ff == RST_BYTE |=> boot_end == FLASH_END && app_end == FLASH_END;
   endproperty
   a_boot0: assert property (p_boot0) else $error("zero boot end not whole flash");

   property p_dbg;
      dbg_req && !dbg_cs_space && locked |=> !dbg_grant && !dbg_sysbus_en;
   endproperty
   a_dbg: assert property (p_dbg) else $error("locked debug reached system bus");

   property p_dec;
      cpu_addr == BASE_FUSES |=> periph_sel == PER_FUSES;
   endproperty
   a_dec: assert property (p_dec) else $error("fuse window misdecoded");

   property p_hold;
      !$past(reset) |-> $stable(cfg0_ff) && $stable(cfg1_ff)
         && $stable(app_blk_ff) && $stable(boot_blk_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("configuration changed after reset");

   c_locked_erase: cover property (chip_erase_req && locked ##1 eeprom_erase);
   c_delay_done:   cover property ($rose(exec_ff) && por_ff);
   c_gpio_drive:   cover property ($rose(pin_gpio_drive_ok));
endmodule

// *** fcd_far_side.sv ***
// Purpose: far side model: slow oscillator and pin interrupt owner
// Assumes: slow oscillator runs free at a quarter of ref_clk
// Notes:   far faster than a real slow source, to keep the run short
module fcd_far_side (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   // pin logic
   input  wire logic drive_ok,
   output logic      pin_irq_en,
   // slow oscillator
   output logic      slow_tick,
   output int        tick_count
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] div_ff = 2'h0;

   always @(posedge ref_clk) begin
      div_ff <= div_ff + 2'h1;
   end
   assign slow_tick = (div_ff == 2'h3);

   // counts only ticks after reset, as the blanking timer does
   always @(posedge ref_clk) begin
      if (reset) begin
         tick_count <= 0;
         pin_irq_en <= 1'h0;
      end else begin
         tick_count <= tick_count + int'(slow_tick);
         pin_irq_en <= drive_ok;
      end
   end
endmodule

// *** tb_fcd_fuse_decode.sv ***
// Purpose: self-checking bench of the configuration decoder
// Assumes: MS_CYC shortened to 4, flash of 64 blocks of 256 bytes
// Notes:   apb master waits for pready under a bound
module tb_fcd_fuse_decode
   import fcd_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk = 1'h0;
   logic        reset = 1'h1;
   logic [7:0]  nv_cfg0 = 8'h00, nv_cfg1 = 8'h00, nv_app_end = 8'h00;
   logic [7:0]  nv_boot_end = 8'h00, nv_key = 8'h00;
   logic        power_on_flag = 1'h0, slow_tick, chip_erase_req = 1'h0;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
   logic [9:0]  paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        e, exec_ready, check_en, eeprom_erase, dbg_grant, dbg_sysbus_en;
   logic [16:0] check_end, boot_end, app_end, flash_addr = 17'h0;
   fcd_region_t flash_region;
   logic [15:0] cpu_addr = 16'h0;
   fcd_periph_t periph_sel;
   logic        dbg_req = 1'h0, dbg_cs_space = 1'h0, irq_en;
   logic        pin_gpio_en, pin_gpio_drive_ok, pin_debug_en, pin_reset_en;
   int          ticks, errors = 0, comparisons = 0;

   always #50 ref_clk = ~ref_clk;

   fcd_fuse_decode #(.FLASH_BLOCKS(64), .MS_CYC(4)) DUT (
      .ref_clk, .reset, .nv_cfg0, .nv_cfg1, .nv_app_end, .nv_boot_end,
      .nv_key, .power_on_flag, .slow_tick, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .exec_ready, .check_en, .check_end,
      .boot_end, .app_end, .flash_addr, .flash_region, .chip_erase_req,
      .eeprom_erase, .cpu_addr, .periph_sel, .dbg_req, .dbg_cs_space,
      .dbg_grant, .dbg_sysbus_en, .pin_gpio_en, .pin_gpio_drive_ok,
      .pin_debug_en, .pin_reset_en);

   fcd_far_side u_far (.ref_clk, .reset, .drive_ok(pin_gpio_drive_ok),
      .pin_irq_en(irq_en), .slow_tick, .tick_count(ticks));

   task automatic summarize();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) begin
         errors++;
         summarize();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // fuse bytes stay stable over the whole reset, sampled on its last edge
   task automatic rst(input logic [7:0] a0, a1, aa, ab, ak, input logic p);
      @(posedge ref_clk);
      reset <= 1'h1;
      nv_cfg0 <= a0;
      nv_cfg1 <= a1;
      nv_app_end <= aa;
      nv_boot_end <= ab;
      nv_key <= ak;
      power_on_flag <= p;
      repeat (4) @(posedge ref_clk);
      reset <= 1'h0;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask

   task automatic erase(input logic x);
      @(posedge ref_clk);
      chip_erase_req <= 1'h1;
      @(posedge ref_clk);
      chip_erase_req <= 1'h0;
      #1;
      chk("erase", x, eeprom_erase);
      @(posedge ref_clk);
      #1;
      chk("erase_end", 0, eeprom_erase);
   endtask

   task automatic dbg(input logic cs, input logic x);
      @(posedge ref_clk);
      dbg_req <= 1'h1;
      dbg_cs_space <= cs;
      @(posedge ref_clk);
      dbg_req <= 1'h0;
      #1;
      chk("grant", x, dbg_grant);
   endtask

   task automatic probe(input logic [16:0] fa, input logic [15:0] ca);
      @(posedge ref_clk);
      flash_addr <= fa;
      cpu_addr <= ca;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic t_regs();
      logic [7:0] v [5] = '{8'h85, 8'h03, 8'h20, 8'h10, 8'h00};
      logic [9:0] ad [5] = '{10'h014, 10'h018, 10'h01c, 10'h020, 10'h028};
      rst(8'h85, 8'h03, 8'h20, 8'h10, 8'h00, 1'h0);
      for (int i = 0; i < 5; i++) begin
         apb(1'h0, ad[i], 32'h0);
         chk("reg_read", {24'h0, v[i]}, r);
         chk("reg_err", 0, e);
      end
      apb(1'h0, 10'h024, 32'h0);
      chk("unmapped_err", 1, e);
      chk("unmapped_data", 0, r);
      apb(1'h0, 10'h015, 32'h0);
      chk("unaligned_err", 1, e);
      apb(1'h1, 10'h020, 32'h55);
      chk("ro_err", 1, e);
      nv_boot_end <= 8'h30;
      apb(1'h0, 10'h020, 32'h0);
      chk("frozen", 32'h10, r);
      chk("boot_end", 32'h1000, boot_end);
      apb(1'h0, 10'h040, 32'h0);
      chk("status_locked", 1, r[0]);
   endtask

   task automatic t_modes();
      logic [31:0] ce [4] = '{32'h4000, 32'h1000, 32'h2000, 32'h0};
      for (int i = 0; i < 4; i++) begin
         rst({i[1:0], 2'h0, i[1:0], 1'h0, i[0]}, 8'h00, 8'h20, 8'h10, 8'hc5, 1'h0);
         chk("check_en", i != 3, check_en);
         if (i != 3)
            chk("check_end", ce[i], check_end);
         chk("gpio_en", i == 0, pin_gpio_en);
         chk("debug_en", i == 1, pin_debug_en);
         chk("reset_en", i == 2, pin_reset_en);
         erase(i[0] == 1'h0);
      end
   endtask

   task automatic t_lock();
      rst(8'h01, 8'h00, 8'h20, 8'h10, 8'h00, 1'h0);
      erase(1'h1);
      chk("sysbus", 0, dbg_sysbus_en);
      dbg(1'h0, 1'h0);
      dbg(1'h1, 1'h1);
      apb(1'h1, 10'h028, 32'hc5);
      erase(1'h0);
      chk("sysbus_open", 1, dbg_sysbus_en);
      dbg(1'h0, 1'h1);
      apb(1'h1, 10'h028, 32'hc4);
      erase(1'h1);
   endtask

   task automatic t_map();
      logic [16:0] fx [6] = '{17'h0fff, 17'h1000, 17'h1fff, 17'h2000, 17'h3fff, 17'h4000};
      fcd_region_t rx [6] = '{REG_BOOT, REG_CODE, REG_CODE, REG_DATA, REG_DATA, REG_OUT};
      logic [15:0] cx [7] = '{16'h0040, 16'h0f00, 16'h1000, 16'h1100, 16'h1280,
                              16'h1300, 16'h127f};
      fcd_periph_t px [7] = '{PER_IO, PER_SYSCFG, PER_FLASHCT, PER_SIGROW, PER_FUSES,
                              PER_USERROW, PER_NONE};
      rst(8'h00, 8'h00, 8'h20, 8'h10, 8'hc5, 1'h0);
      for (int i = 0; i < 7; i++) begin
         probe(fx[i % 6], cx[i]);
         chk("region", rx[i % 6], flash_region);
         chk("periph", px[i], periph_sel);
      end
      rst(8'h00, 8'h00, 8'h00, 8'h10, 8'hc5, 1'h0);
      probe(17'h3fff, 16'h0);
      chk("region_zero_app", REG_CODE, flash_region);
      chk("app_end_zero", 32'h4000, app_end);
      rst(8'h00, 8'h00, 8'h20, 8'h00, 8'hc5, 1'h0);
      probe(17'h3000, 16'h0);
      chk("region_zero_boot", REG_BOOT, flash_region);
      chk("boot_end_zero", 32'h4000, boot_end);
   endtask

   task automatic t_start();
      int d;
      int n;
      for (int s = 3; s < 8; s += 4) begin
         d = 4 << (s - 1);
         rst(8'h04, s[7:0], 8'h20, 8'h10, 8'hc5, 1'h1);
         n = 3;
         chk("exec_early", 0, exec_ready);
         while (exec_ready !== 1'h1 && n < 1000) begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         chk("exec_time", 1, n >= d && n <= d + 6);
      end
      rst(8'h04, 8'h07, 8'h20, 8'h10, 8'hc5, 1'h0);
      chk("exec_warm", 1, exec_ready);
      rst(8'h04, 8'h00, 8'h20, 8'h10, 8'hc5, 1'h1);
      chk("exec_zero", 1, exec_ready);
   endtask

   task automatic wait_ticks(input int t);
      int k;
      k = 0;
      while (ticks < t && k < 5000) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      if (k >= 5000) begin
         errors++;
         summarize();
      end
   endtask

   // the driver must stay off until the last blanking tick has passed
   task automatic t_blank();
      rst(8'h00, 8'h00, 8'h20, 8'h10, 8'hc5, 1'h0);
      chk("drive_start", 0, pin_gpio_drive_ok);
      wait_ticks(767);
      chk("drive_767", 0, pin_gpio_drive_ok);
      chk("irq_early", 0, irq_en);
      wait_ticks(768);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("drive_768", 1, pin_gpio_drive_ok);
      chk("irq_late", 1, irq_en);
      apb(1'h0, 10'h040, 32'h0);
      chk("status", 32'h6, r);
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      t_regs();
      t_modes();
      t_lock();
      t_map();
      t_start();
      t_blank();
      summarize();
   end
endmodule
